/* codec_slot_pkg.sv */
// Shared constants for the codec slot control and status block.
// Assumes a 32-bit register port and a 16-slot, 16-bit-per-slot frame.
package codec_slot_pkg;

  // ==========================================================
  // Register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] RX_SLOT_MASK_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] TX_SLOT_MASK_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] RX_DATA_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] TX_DATA_OFS = 8'h1C;

  // ==========================================================
  // Field positions
  localparam int MODE_BIT = 0;
  localparam int RX_FULL_BIT = 2;
  localparam int TX_UNDERFLOW_BIT = 1;
  localparam int TX_EMPTY_BIT = 0;
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_UNF_BIT = 1;
  localparam int IRQ_W = 2;

  // ==========================================================
  // Frame geometry and reset values
  localparam int NUM_SLOTS = 16;
  localparam int SLOT_W = 16;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] LAST_BIT = 4'hF;
  localparam logic [CNT_W-1:0] LAST_SLOT = 4'hF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [NUM_SLOTS-1:0] SLOT_MASK_RESET = 16'h0000;
  localparam logic [SLOT_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_ZERO = 2'h0;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

  // ==========================================================
  // Pins passing the synchroniser: bit clock, frame sync, data in
  localparam int PIN_COUNT = 3;
  localparam int PIN_BCLK = 0;
  localparam int PIN_FSYNC = 1;
  localparam int PIN_SDI = 2;

  typedef enum logic {WAIT_SYNC, IN_FRAME} frame_state_e;

endpackage

/* pin_sync.sv */
// Two-flop synchronisers for the serial link pins.
// Assumes the pins are asynchronous to sys_clk.
`timescale 1ns/1ps
module pin_sync
  import codec_slot_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [PIN_COUNT-1:0] pinIn,
  output logic [PIN_COUNT-1:0] pinSync
);

  logic [PIN_COUNT-1:0] stage1;

  // ==========================================================
  // First stage feeds only the second stage
  genvar i;
  generate
    for (i = 0; i < PIN_COUNT; i++) begin : gSync
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          stage1[i] <= 1'b0;
          pinSync[i] <= 1'b0;
        end else begin
          stage1[i] <= pinIn[i];
          pinSync[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule

/* slot_counter.sv */
// Bit and slot position counter of the serial frame.
// Assumes one-cycle bit clock rise pulses and a synchronised frame sync.
`timescale 1ns/1ps
module slot_counter
  import codec_slot_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic bitRise,
  input wire logic frameSync,
  output logic [CNT_W-1:0] bitPos,
  output logic [CNT_W-1:0] slotPos,
  output logic inFrame
);

  frame_state_e state;

  assign inFrame = (state == IN_FRAME);

  // ==========================================================
  // Sync at a rise marks the frame; data starts at the next rise
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= WAIT_SYNC;
      bitPos <= CNT_ZERO;
      slotPos <= CNT_ZERO;
    end else if (bitRise) begin
      if (frameSync) begin
        state <= IN_FRAME;
        bitPos <= CNT_ZERO;
        slotPos <= CNT_ZERO;
      end else begin
        unique case (state)
          WAIT_SYNC: begin
            bitPos <= CNT_ZERO;
            slotPos <= CNT_ZERO;
          end
          IN_FRAME: begin
            bitPos <= bitPos + CNT_ONE;
            if (bitPos == LAST_BIT) begin
              slotPos <= slotPos + CNT_ONE;
              if (slotPos == LAST_SLOT) begin
                state <= WAIT_SYNC;
              end
            end
          end
        endcase
      end
    end
  end

endmodule

/* codec_slot_control.sv */
// Slot selection, data buffers and status of the codec serial interface.
// Assumes a codec driving bit clock and frame sync, and a register master
// that holds strobes for one cycle and takes read data the cycle after.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

// Summary of operation
// - Receive-full flag sets on a new received word, clears once it is read.
// - Underflow flag sets when an enabled slot finds no transmit word.
// - Serial input captured only in slots whose receive mask bit is one.
// - Transmit word shifted out only in slots whose transmit mask bit is one.
// - Disabled slots tri-state the output or drive it low, per output mode.
// - Both slot masks reset to zero and stay fully readable and writable.
module codec_slot_control
  import codec_slot_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [DATA_W-1:0] rdData,
  input wire logic bitClk,
  input wire logic frameSync,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOutEn,
  output logic irq
);

  // ==========================================================
  // Link pin sampling
  logic [PIN_COUNT-1:0] pinSync;
  logic bclkS;
  logic fsS;
  logic sdiS;
  logic bclkPrev;
  logic bitRise;
  logic bitFall;
  logic [CNT_W-1:0] bitPos;
  logic [CNT_W-1:0] slotPos;
  logic inFrame;

  pin_sync uSync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pinIn({serialDataIn, frameSync, bitClk}),
    .pinSync(pinSync)
  );

  assign bclkS = pinSync[PIN_BCLK];
  assign fsS = pinSync[PIN_FSYNC];
  assign sdiS = pinSync[PIN_SDI];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bclkPrev <= 1'b0;
    end else begin
      bclkPrev <= bclkS;
    end
  end

  assign bitRise = bclkS && !bclkPrev;
  assign bitFall = !bclkS && bclkPrev;

  slot_counter uCount (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .bitRise(bitRise),
    .frameSync(fsS),
    .bitPos(bitPos),
    .slotPos(slotPos),
    .inFrame(inFrame)
  );

  // ==========================================================
  // Register state
  logic idleDriveLow;
  logic [NUM_SLOTS-1:0] rxSlotMask;
  logic [NUM_SLOTS-1:0] txSlotMask;
  logic [IRQ_W-1:0] irqStatus;
  logic [IRQ_W-1:0] irqMask;
  logic [SLOT_W-1:0] rxShift;
  logic [SLOT_W-1:0] rxData;
  logic rxFull;
  logic [SLOT_W-1:0] txBuf;
  logic [SLOT_W-1:0] txShift;
  logic txFull;
  logic txUnderflow;

  logic wrCtrl;
  logic wrIrqStatus;
  logic wrIrqMask;
  logic wrRxMask;
  logic wrTxMask;
  logic wrTxData;
  logic rdRxData;
  logic rxSample;
  logic rxWordDone;
  logic txActive;
  logic txLoad;
  logic underflowEvent;
  logic [IRQ_W-1:0] irqEvents;

  assign wrCtrl = wrEn && (addr == CTRL_OFS);
  assign wrIrqStatus = wrEn && (addr == IRQ_STATUS_OFS);
  assign wrIrqMask = wrEn && (addr == IRQ_MASK_OFS);
  assign wrRxMask = wrEn && (addr == RX_SLOT_MASK_OFS);
  assign wrTxMask = wrEn && (addr == TX_SLOT_MASK_OFS);
  assign wrTxData = wrEn && (addr == TX_DATA_OFS);
  assign rdRxData = rdEn && (addr == RX_DATA_OFS);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idleDriveLow <= 1'b0;
    end else if (wrCtrl) begin
      idleDriveLow <= wrData[MODE_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxSlotMask <= SLOT_MASK_RESET;
      txSlotMask <= SLOT_MASK_RESET;
    end else begin
      if (wrRxMask) begin
        rxSlotMask <= wrData[NUM_SLOTS-1:0];
      end
      if (wrTxMask) begin
        txSlotMask <= wrData[NUM_SLOTS-1:0];
      end
    end
  end

  // ==========================================================
  // Receive path
  assign rxSample = bitRise && !fsS && inFrame && rxSlotMask[slotPos];
  assign rxWordDone = rxSample && (bitPos == LAST_BIT);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxShift <= WORD_ZERO;
      rxData <= WORD_ZERO;
    end else if (rxSample) begin
      rxShift <= {rxShift[SLOT_W-2:0], sdiS};
      if (rxWordDone) begin
        rxData <= {rxShift[SLOT_W-2:0], sdiS};
      end
    end
  end

  // New word wins over a read in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxFull <= 1'b0;
    end else if (rxWordDone) begin
      rxFull <= 1'b1;
    end else if (rdRxData) begin
      rxFull <= 1'b0;
    end
  end

  // ==========================================================
  // Transmit path
  assign txActive = bitFall && inFrame && txSlotMask[slotPos];
  assign txLoad = txActive && (bitPos == CNT_ZERO);
  assign underflowEvent = txLoad && !txFull;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txBuf <= WORD_ZERO;
    end else if (wrTxData) begin
      txBuf <= wrData[SLOT_W-1:0];
    end
  end

  // A slot that finds no word sends zeros rather than stale data
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txShift <= WORD_ZERO;
    end else if (txLoad) begin
      txShift <= txFull ? {txBuf[SLOT_W-2:0], 1'b0} : WORD_ZERO;
    end else if (txActive) begin
      txShift <= {txShift[SLOT_W-2:0], 1'b0};
    end
  end

  // Load wins over a write landing in the same cycle; the word is then
  // consumed and the write counts as the next one only if it comes later
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txFull <= 1'b0;
    end else if (txLoad) begin
      txFull <= 1'b0;
    end else if (wrTxData) begin
      txFull <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txUnderflow <= 1'b0;
    end else if (underflowEvent) begin
      txUnderflow <= 1'b1;
    end else if (wrTxData) begin
      txUnderflow <= 1'b0;
    end
  end

  // Output changes only on bit clock falls so the codec samples a settled bit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      serialDataOut <= 1'b0;
      serialDataOutEn <= 1'b0;
    end else if (bitFall) begin
      if (txActive) begin
        serialDataOutEn <= 1'b1;
        if (txLoad) begin
          serialDataOut <= txFull && txBuf[SLOT_W-1];
        end else begin
          serialDataOut <= txShift[SLOT_W-1];
        end
      end else begin
        serialDataOut <= 1'b0;
        serialDataOutEn <= idleDriveLow;
      end
    end
  end

  // ==========================================================
  // Interrupts
  assign irqEvents = {underflowEvent, rxWordDone};

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_W; gi++) begin : gIrq
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          irqStatus[gi] <= 1'b0;
        end else if (irqEvents[gi]) begin
          irqStatus[gi] <= 1'b1;
        end else if (wrIrqStatus && wrData[gi]) begin
          irqStatus[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqMask <= IRQ_ZERO;
    end else if (wrIrqMask) begin
      irqMask <= wrData[IRQ_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqMask);
    end
  end

  // ==========================================================
  // Read port
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= READ_ZERO;
    end else if (rdEn) begin
      rdData <= READ_ZERO;
      unique case (addr)
        CTRL_OFS: rdData[MODE_BIT] <= idleDriveLow;
        STATUS_OFS: begin
          rdData[RX_FULL_BIT] <= rxFull;
          rdData[TX_UNDERFLOW_BIT] <= txUnderflow;
          rdData[TX_EMPTY_BIT] <= !txFull;
        end
        IRQ_STATUS_OFS: rdData[IRQ_W-1:0] <= irqStatus;
        IRQ_MASK_OFS: rdData[IRQ_W-1:0] <= irqMask;
        RX_SLOT_MASK_OFS: rdData[NUM_SLOTS-1:0] <= rxSlotMask;
        TX_SLOT_MASK_OFS: rdData[NUM_SLOTS-1:0] <= txSlotMask;
        RX_DATA_OFS: rdData[SLOT_W-1:0] <= rxData;
        default: rdData <= READ_ZERO;
      endcase
    end else begin
      rdData <= READ_ZERO;
    end
  end

  // ==========================================================
  // Assertions
  sequence frameStart;
    bitRise && fsS;
  endsequence

  sequence rxReadAlone;
    rdRxData && !rxWordDone;
  endsequence

  rx_full_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rxWordDone |=> rxFull && (rxData[0] == $past(sdiS)))
    else $error("receive-full not set after word");

  rx_full_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rxReadAlone |=> !rxFull)
    else $error("receive-full not cleared by read");

  tx_unf_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    underflowEvent |=> txUnderflow ##1 (txUnderflow || $past(wrTxData)))
    else $error("underflow flag not set");

  tx_unf_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !txUnderflow && !underflowEvent |=> !txUnderflow)
    else $error("underflow flag set without cause");

  rx_ignore_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bitRise && !rxSlotMask[slotPos] |=> $stable(rxShift) && $stable(rxData))
    else $error("input captured in disabled slot");

  tx_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    txLoad && txFull |=> serialDataOutEn && (serialDataOut == $past(txBuf[SLOT_W-1])))
    else $error("enabled slot not driven");

  // Mode as it stood at the fall; a mode write may land in that same cycle
  idle_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bitFall && !txActive |=> !serialDataOut && (serialDataOutEn == $past(idleDriveLow)))
    else $error("disabled slot output wrong");

  mask_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wrRxMask ##1 !wrRxMask ##1 (rdEn && addr == RX_SLOT_MASK_OFS && !wrRxMask)
      |=> rdData[NUM_SLOTS-1:0] == $past(wrData[NUM_SLOTS-1:0], 3))
    else $error("receive mask readback wrong");

  tx_mask_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wrTxMask ##1 !wrTxMask ##1 (rdEn && addr == TX_SLOT_MASK_OFS && !wrTxMask)
      |=> rdData[NUM_SLOTS-1:0] == $past(wrData[NUM_SLOTS-1:0], 3))
    else $error("transmit mask readback wrong");

  slot_restart_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    frameStart |=> inFrame && slotPos == CNT_ZERO && bitPos == CNT_ZERO)
    else $error("frame sync did not restart slots");

endmodule

/* codec_model.sv */
// Behavioural codec on the far side of the slot-based serial link.
// Assumes the block under test samples the link pins with its own clock.
`timescale 1ns/1ps
module codec_model (
  output logic bitClk,
  output logic frameSync,
  output logic serialDataIn,
  input wire logic serialDataOut,
  input wire logic serialDataOutEn
);
  // ==========================================================
  // Pin level and idle state
  wire lineLevel = serialDataOutEn ? serialDataOut : 1'bz;

  initial begin
    bitClk = 1'b0;
    frameSync = 1'b0;
    serialDataIn = 1'b0;
  end

  // ==========================================================
  // One frame: sync bit, then 256 data bits, slot 0 first, MSB first
  // Clock stands low between frames; the 200 ns period runs only inside.
  // Output is taken late in the high phase, since the block's
  // synchroniser puts its answer close to the rising edge.
  task automatic run_frame(input logic [255:0] sdiBits, output logic [255:0] seen);
    int i;
    // Called just after a clock edge; the offset keeps pin edges clear of it
    #3;
    frameSync = 1'b1;
    #100 bitClk = 1'b1;
    #100 bitClk = 1'b0;
    frameSync = 1'b0;
    for (i = 0; i < 256; i++) begin
      serialDataIn = sdiBits[255-i];
      #100 bitClk = 1'b1;
      #95 seen[255-i] = lineLevel;
      #5 bitClk = 1'b0;
    end
    // Line no longer carries data; keep it from looking stable
    serialDataIn = ~serialDataIn;
  endtask
endmodule

/* tb.sv */
// Self-checking bench for the codec slot control and status block.
// Assumes codec_model on the link pins and a plain one-cycle register port.
`timescale 1ns/1ps
module tb
  import codec_slot_pkg::*;
;
  typedef struct packed {
    logic doWr;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] e;
  } row_s;

  logic sys_clk, rst_n, wrEn, rdEn, irq, bitClk, frameSync, serialDataIn;
  logic serialDataOut, serialDataOutEn;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wrData, rdData;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  row_s rows[8];

  codec_slot_control u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrEn(wrEn),
    .rdEn(rdEn), .rdData(rdData), .bitClk(bitClk), .frameSync(frameSync),
    .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
    .serialDataOutEn(serialDataOutEn), .irq(irq)
  );

  codec_model u_codec (
    .bitClk(bitClk), .frameSync(frameSync), .serialDataIn(serialDataIn),
    .serialDataOut(serialDataOut), .serialDataOutEn(serialDataOutEn)
  );

  // ==========================================================
  // Clock, timeout and verdict
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Two frames of about 2100 cycles plus register traffic
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  // ==========================================================
  // Register port and comparison tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge sys_clk);
    wrEn <= 1'b0;
  endtask

  task automatic rdchk(input string name, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge sys_clk);
    rdEn <= 1'b0;
    #1 chk(name, rdData, exp);
  endtask

  task automatic irqchk(input logic exp);
    repeat (3) @(posedge sys_clk);
    #1 chk("irq", {31'h0, irq}, {31'h0, exp});
  endtask

  function automatic logic [15:0] word(input int s);
    return {s[3:0], ~s[3:0], 8'h5A};
  endfunction

  // ==========================================================
  // Frame with a distinct word per slot on the input line
  // First enabled transmit slot sends w0; only w0 is written, so later ones are checked against w1.
  task automatic frame(input logic mode, input logic [15:0] rxm, input logic [15:0] txm,
                       input logic [15:0] w0, input logic [15:0] w1);
    logic [255:0] sdi, seen;
    logic [15:0] exp;
    int s, k;
    k = 0;
    wr(CTRL_OFS, {31'h0, mode});
    wr(RX_SLOT_MASK_OFS, {16'h0, rxm});
    wr(TX_SLOT_MASK_OFS, {16'h0, txm});
    wr(TX_DATA_OFS, {16'h0, w0});
    for (s = 0; s < 16; s++) begin
      sdi[255-16*s -: 16] = word(s);
    end
    u_codec.run_frame(sdi, seen);
    repeat (8) @(posedge sys_clk);
    for (s = 0; s < 16; s++) begin
      if (txm[s]) begin
        exp = (k == 0) ? w0 : w1;
        k++;
      end else begin
        exp = mode ? 16'h0000 : 16'hzzzz;
      end
      chk("slotOut", {16'h0, seen[255-16*s -: 16]}, {16'h0, exp});
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    addr = 8'h00;
    wrData = 32'h0000_0000;
    wrEn = 1'b0;
    rdEn = 1'b0;
    rows[0] = '{1'b0, RX_SLOT_MASK_OFS, 32'h0, 32'h0};
    rows[1] = '{1'b0, TX_SLOT_MASK_OFS, 32'h0, 32'h0};
    rows[2] = '{1'b0, STATUS_OFS, 32'h0, 32'h1};
    rows[3] = '{1'b1, RX_SLOT_MASK_OFS, 32'hFFFF_A5C3, 32'h0000_A5C3};
    rows[4] = '{1'b1, TX_SLOT_MASK_OFS, 32'h0000_5A3C, 32'h0000_5A3C};
    rows[5] = '{1'b1, STATUS_OFS, 32'hFFFF_FFFF, 32'h1};
    rows[6] = '{1'b1, 8'h40, 32'hFFFF_FFFF, 32'h0};
    rows[7] = '{1'b1, IRQ_MASK_OFS, 32'h3, 32'h3};
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].doWr) begin
        wr(rows[i].a, rows[i].d);
      end
      rdchk("regRow", rows[i].a, rows[i].e);
    end
    // Tri-state idle, one receive slot, one transmit slot
    frame(1'b0, 16'h0004, 16'h0020, 16'hBEEF, 16'h0000);
    rdchk("status", STATUS_OFS, 32'h5);
    irqchk(1'b1);
    rdchk("rxData", RX_DATA_OFS, {16'h0, word(2)});
    rdchk("status", STATUS_OFS, 32'h1);
    wr(IRQ_STATUS_OFS, 32'h3);
    irqchk(1'b0);
    // Drive-low idle, second transmit slot underflows, later receive word wins
    frame(1'b1, 16'h8001, 16'h0003, 16'h8001, 16'h0000);
    rdchk("status", STATUS_OFS, 32'h7);
    rdchk("irqStatus", IRQ_STATUS_OFS, 32'h3);
    rdchk("rxData", RX_DATA_OFS, {16'h0, word(15)});
    wr(IRQ_MASK_OFS, 32'h0);
    irqchk(1'b0);
    wr(IRQ_MASK_OFS, 32'h2);
    irqchk(1'b1);
    wr(IRQ_STATUS_OFS, 32'h3);
    irqchk(1'b0);
    wr(TX_DATA_OFS, 32'h1234);
    rdchk("status", STATUS_OFS, 32'h0);
    // Reset in mid-run returns masks and flags to their reset values
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdchk("rxMaskRst", RX_SLOT_MASK_OFS, 32'h0);
    rdchk("txMaskRst", TX_SLOT_MASK_OFS, 32'h0);
    rdchk("statusRst", STATUS_OFS, 32'h1);
    end_of_test();
  end
endmodule
